// File: sep_serial_eeprom.sv
// Purpose: Pin-level logic of a three/four-wire serial EEPROM of 16-bit words.
// Assumes: Pins are sampled by a 250 MHz clock; rst is the power-up reset.
// Notes:   Finished program jobs queue in a small FIFO ahead of the timer.
//
// Behaviour
// - Device answers only while select high; low select means standby.
// - A started erase or write completes; standby waits for its end.
// - Select low holds instruction decoding in reset, dropping partial frames.
// - Opcode, address and data bits are sampled on serial clock rising edges.
// - Each outgoing bit is launched by a serial clock rising edge.
// - Serial clock may pause at either level; shift progress is kept.
// - Serial clock is ignored while select is low.
// - Before a start bit, clock edges change nothing.
// - Erase and write cycles are timed internally, no serial clock needed.
// - Execute only after all bits are in; then ignore inputs until deselect.
// - After a program start and a deselect gap, select high shows ready/busy.
// - Word program ends within 2 ms; erase-all and write-all within 15 ms.
// - A word write erases that word first, in the same timed cycle.
// - Array holds 64 words of 16 bits, each one addressed unit.
// - Start bit is the first rising edge with select and serial input high.
// - After power-up programming is locked until an unlock instruction.
// - A read emits one leading zero then the addressed 16-bit word.
// - Read data goes out most significant bit first.
`default_nettype none

module sep_fifo #(
	parameter int unsigned WIDTH = sep_pkg::FIFO_W,
	parameter int unsigned DEPTH = sep_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// Filling side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Draining side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] store_reg [DEPTH];
	logic [WIDTH-1:0] store_next [DEPTH];
	logic [PW-1:0]    wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
	logic [PW:0]      count_reg, count_next;
	logic             push, pop;

	assign inReady  = count_reg != (PW+1)'(DEPTH);
	assign outValid = count_reg != '0;
	assign outData  = store_reg[rdPtr_reg];

	always_comb begin
		push       = inValid && inReady;
		pop        = outValid && outReady;
		store_next = store_reg;
		wrPtr_next = wrPtr_reg;
		rdPtr_next = rdPtr_reg;
		count_next = count_reg;
		if (push) begin
			store_next[wrPtr_reg] = inData;
			wrPtr_next = (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
		end
		if (pop) begin
			rdPtr_next = (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
		end
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				store_reg[i] <= '0;
			end
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			store_reg <= store_next;
			wrPtr_reg <= wrPtr_next;
			rdPtr_reg <= rdPtr_next;
			count_reg <= count_next;
		end
	end

endmodule : sep_fifo

module sep_serial_eeprom #(
	parameter int unsigned WRITE_CYC = sep_pkg::WRITE_CYCLES,
	parameter int unsigned ERASE_CYC = sep_pkg::ERASE_CYCLES,
	parameter int unsigned BULK_CYC  = sep_pkg::BULK_CYCLES
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Serial pins
	input  wire logic deviceSelect,
	input  wire logic serialClock,
	input  wire logic serialIn,
	output logic      serialOut,
	output logic      serialOutEn,
	// Power state
	output logic      standby
);
	// A pin change counts once stages two and three agree
	function automatic logic settle(input logic b, input logic c, input logic f);
		settle = (b == c) ? b : f;
	endfunction : settle

	// Pin synchronisers: bit 0 select, bit 1 clock, bit 2 data
	logic [2:0] syncA_reg, syncB_reg, syncC_reg, filt_reg, filt_next;
	logic       csNow, sinNow, sclkRise;

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			filt_next[i] = settle(syncB_reg[i], syncC_reg[i], filt_reg[i]);
		end
		csNow    = filt_next[0];
		sinNow   = filt_next[2];
		sclkRise = csNow && filt_next[1] && !filt_reg[1];
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			syncA_reg <= 3'h0;
			syncB_reg <= 3'h0;
			syncC_reg <= 3'h0;
			filt_reg  <= 3'h0;
		end else begin
			syncA_reg <= {serialIn, serialClock, deviceSelect};
			syncB_reg <= syncA_reg;
			syncC_reg <= syncB_reg;
			filt_reg  <= filt_next;
		end
	end

	// Storage array and FIFO wiring
	logic [15:0]             mem_reg [sep_pkg::WORDS];
	logic [15:0]             mem_next [sep_pkg::WORDS];
	logic                    fifoInReady, fifoOutValid, fifoOutReady;
	logic [sep_pkg::FIFO_W-1:0] fifoOutData;

	// Instruction decoder
	sep_pkg::sep_dec_t  decState_reg, decState_next;
	sep_pkg::sep_kind_t kind_reg, kind_next;
	logic [3:0]  bitCnt_reg, bitCnt_next;
	logic [7:0]  head_reg, head_next, headFull;
	logic [15:0] data_reg, data_next, readSh_reg, readSh_next;
	logic [4:0]  readCnt_reg, readCnt_next;
	logic        readEn_reg, readEn_next, readBit_reg, readBit_next;
	logic        progEn_reg, progEn_next;
	logic        startSeen, pushValid, pushDone;

	always_comb begin
		decState_next = decState_reg;
		kind_next     = kind_reg;
		bitCnt_next   = bitCnt_reg;
		head_next     = head_reg;
		data_next     = data_reg;
		readSh_next   = readSh_reg;
		readCnt_next  = readCnt_reg;
		readEn_next   = readEn_reg;
		readBit_next  = readBit_reg;
		progEn_next   = progEn_reg;
		headFull      = {head_reg[6:0], sinNow};
		pushValid     = decState_reg == sep_pkg::D_PUSH;
		pushDone      = pushValid && fifoInReady;
		startSeen     = decState_reg == sep_pkg::D_IDLE && sclkRise && sinNow;
		if (!csNow && !pushValid) begin
			// Accepted jobs survive deselect; anything partial is dropped
			decState_next = sep_pkg::D_IDLE;
			bitCnt_next   = 4'h0;
			readEn_next   = 1'b0;
		end else if (pushValid) begin
			if (fifoInReady) begin
				decState_next = csNow ? sep_pkg::D_DONE : sep_pkg::D_IDLE;
			end
		end else if (sclkRise) begin
			unique case (decState_reg)
				sep_pkg::D_IDLE: begin
					if (sinNow) begin
						decState_next = sep_pkg::D_HEAD;
						bitCnt_next   = 4'h0;
					end
				end
				sep_pkg::D_HEAD: begin
					head_next   = headFull;
					bitCnt_next = bitCnt_reg + 4'h1;
					if (bitCnt_reg == sep_pkg::HEAD_LAST) begin
						bitCnt_next = 4'h0;
						unique case (headFull[sep_pkg::OP_HI:sep_pkg::OP_LO])
							sep_pkg::OP_READ: begin
								decState_next = sep_pkg::D_READ;
								readEn_next   = 1'b1;
								readBit_next  = 1'b0;
								readSh_next   = mem_reg[headFull[sep_pkg::ADDR_W-1:0]];
								readCnt_next  = 5'h0;
							end
							sep_pkg::OP_WRITE: begin
								decState_next = sep_pkg::D_DATA;
								kind_next     = sep_pkg::PK_WRITE;
							end
							sep_pkg::OP_ERASE: begin
								kind_next     = sep_pkg::PK_ERASE;
								decState_next = progEn_reg ? sep_pkg::D_PUSH : sep_pkg::D_DONE;
							end
							sep_pkg::OP_SPECIAL: begin
								unique case (headFull[sep_pkg::SUB_HI:sep_pkg::SUB_LO])
									sep_pkg::SUB_UNLOCK: begin
										progEn_next   = 1'b1;
										decState_next = sep_pkg::D_DONE;
									end
									sep_pkg::SUB_LOCK: begin
										progEn_next   = 1'b0;
										decState_next = sep_pkg::D_DONE;
									end
									sep_pkg::SUB_ERASE_ALL: begin
										kind_next     = sep_pkg::PK_ERASE_ALL;
										decState_next = progEn_reg ? sep_pkg::D_PUSH : sep_pkg::D_DONE;
									end
									sep_pkg::SUB_WRITE_ALL: begin
										kind_next     = sep_pkg::PK_WRITE_ALL;
										decState_next = sep_pkg::D_DATA;
									end
								endcase
							end
						endcase
					end
				end
				sep_pkg::D_DATA: begin
					data_next   = {data_reg[14:0], sinNow};
					bitCnt_next = bitCnt_reg + 4'h1;
					if (bitCnt_reg == sep_pkg::DATA_LAST) begin
						bitCnt_next   = 4'h0;
						decState_next = progEn_reg ? sep_pkg::D_PUSH : sep_pkg::D_DONE;
					end
				end
				sep_pkg::D_READ: begin
					if (readCnt_reg == sep_pkg::READ_BITS) begin
						readEn_next   = 1'b0;
						decState_next = sep_pkg::D_DONE;
					end else begin
						readBit_next = readSh_reg[15];
						readSh_next  = {readSh_reg[14:0], 1'b0};
						readCnt_next = readCnt_reg + 5'h1;
					end
				end
				sep_pkg::D_PUSH, sep_pkg::D_DONE: begin
				end
				default: decState_next = sep_pkg::D_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			decState_reg <= sep_pkg::D_IDLE;
			kind_reg     <= sep_pkg::PK_WRITE;
			bitCnt_reg   <= 4'h0;
			head_reg     <= 8'h00;
			data_reg     <= 16'h0000;
			readSh_reg   <= 16'h0000;
			readCnt_reg  <= 5'h00;
			readEn_reg   <= 1'b0;
			readBit_reg  <= 1'b0;
			progEn_reg   <= 1'b0;
		end else begin
			decState_reg <= decState_next;
			kind_reg     <= kind_next;
			bitCnt_reg   <= bitCnt_next;
			head_reg     <= head_next;
			data_reg     <= data_next;
			readSh_reg   <= readSh_next;
			readCnt_reg  <= readCnt_next;
			readEn_reg   <= readEn_next;
			readBit_reg  <= readBit_next;
			progEn_reg   <= progEn_next;
		end
	end

	AST_DESELECT_RESETS: assert property (@(posedge clock) disable iff (rst)
		(!csNow && decState_reg != sep_pkg::D_PUSH) |=> decState_reg == sep_pkg::D_IDLE && !readEn_reg)
		else $error("Decoder not reset by deselect");
	AST_WAIT_FOR_START: assert property (@(posedge clock) disable iff (rst)
		(decState_reg == sep_pkg::D_IDLE && csNow && !sinNow) |=> decState_reg == sep_pkg::D_IDLE)
		else $error("Left idle without a start bit");
	AST_START_DETECT: assert property (@(posedge clock) disable iff (rst)
		startSeen |=> decState_reg == sep_pkg::D_HEAD && bitCnt_reg == 4'h0)
		else $error("Start bit not taken");
	AST_SAMPLE_ON_RISE: assert property (@(posedge clock) disable iff (rst)
		(decState_reg == sep_pkg::D_HEAD && sclkRise) |=> head_reg[0] == $past(sinNow))
		else $error("Header bit not sampled on rising edge");
	AST_PAUSE_KEEPS: assert property (@(posedge clock) disable iff (rst)
		(decState_reg == sep_pkg::D_DATA && csNow && !sclkRise) |=> $stable(bitCnt_reg) && $stable(data_reg))
		else $error("Shift progress moved without a clock edge");
	AST_DONE_HOLDS: assert property (@(posedge clock) disable iff (rst)
		(decState_reg == sep_pkg::D_DONE && csNow) |=> decState_reg == sep_pkg::D_DONE)
		else $error("Finished frame reacted to inputs");
	AST_READ_DUMMY: assert property (@(posedge clock) disable iff (rst)
		(decState_reg == sep_pkg::D_HEAD ##1 decState_reg == sep_pkg::D_READ) |-> readEn_reg && !readBit_reg)
		else $error("Read did not start with a zero bit");
	AST_LAUNCH_ON_RISE: assert property (@(posedge clock) disable iff (rst)
		(decState_reg == sep_pkg::D_READ && csNow && !sclkRise) |=> $stable(readBit_reg))
		else $error("Read bit changed without a clock edge");
	AST_LOCKED_NO_JOB: assert property (@(posedge clock) disable iff (rst)
		(decState_reg != sep_pkg::D_PUSH ##1 decState_reg == sep_pkg::D_PUSH) |-> $past(progEn_reg))
		else $error("Program job queued while locked");

	// Job queue; a full queue stalls the decoder in its push state
	sep_fifo #(.WIDTH(sep_pkg::FIFO_W), .DEPTH(sep_pkg::FIFO_DEPTH)) jobQueue (
		.clock    (clock),
		.rst      (rst),
		.inValid  (pushValid),
		.inReady  (fifoInReady),
		.inData   ({kind_reg, head_reg[sep_pkg::ADDR_W-1:0], data_reg}),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOutData)
	);

	// Self-timed executor, runs on the system clock only
	sep_pkg::sep_exec_t  xState_reg, xState_next;
	sep_pkg::sep_kind_t  xKind_reg, xKind_next;
	logic [5:0]  xAddr_reg, xAddr_next;
	logic [15:0] xData_reg, xData_next;
	logic [31:0] timer_reg, timer_next;
	logic        busy;

	always_comb begin
		xState_next  = xState_reg;
		xKind_next   = xKind_reg;
		xAddr_next   = xAddr_reg;
		xData_next   = xData_reg;
		timer_next   = timer_reg;
		mem_next     = mem_reg;
		fifoOutReady = xState_reg == sep_pkg::X_IDLE;
		unique case (xState_reg)
			sep_pkg::X_IDLE: begin
				if (fifoOutValid) begin
					xKind_next = sep_pkg::sep_kind_t'(fifoOutData[sep_pkg::FIFO_W-1 -: 2]);
					xAddr_next = fifoOutData[sep_pkg::WORD_W +: sep_pkg::ADDR_W];
					xData_next = fifoOutData[sep_pkg::WORD_W-1:0];
					unique case (sep_pkg::sep_kind_t'(fifoOutData[sep_pkg::FIFO_W-1 -: 2]))
						sep_pkg::PK_WRITE: begin
							xState_next = sep_pkg::X_ERASE;
							timer_next  = 32'(WRITE_CYC / 2 - 1);
						end
						sep_pkg::PK_ERASE: begin
							xState_next = sep_pkg::X_ERASE;
							timer_next  = 32'(ERASE_CYC - 1);
						end
						sep_pkg::PK_ERASE_ALL: begin
							xState_next = sep_pkg::X_ERASE;
							timer_next  = 32'(BULK_CYC - 1);
						end
						sep_pkg::PK_WRITE_ALL: begin
							xState_next = sep_pkg::X_STORE;
							timer_next  = 32'(BULK_CYC - 1);
						end
					endcase
				end
			end
			sep_pkg::X_ERASE, sep_pkg::X_STORE: begin
				timer_next = timer_reg - 32'h1;
				if (timer_reg == 32'h0) begin
					xState_next = sep_pkg::X_IDLE;
					if (xState_reg == sep_pkg::X_ERASE) begin
						for (int i = 0; i < sep_pkg::WORDS; i++) begin
							if (xKind_reg == sep_pkg::PK_ERASE_ALL || 6'(i) == xAddr_reg) begin
								mem_next[i] = sep_pkg::ERASED;
							end
						end
						if (xKind_reg == sep_pkg::PK_WRITE) begin
							xState_next = sep_pkg::X_STORE;
							timer_next  = 32'(WRITE_CYC - WRITE_CYC / 2 - 1);
						end
					end else begin
						for (int i = 0; i < sep_pkg::WORDS; i++) begin
							if (xKind_reg == sep_pkg::PK_WRITE_ALL || 6'(i) == xAddr_reg) begin
								mem_next[i] = xData_reg;
							end
						end
					end
				end
			end
			default: xState_next = sep_pkg::X_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			xState_reg <= sep_pkg::X_IDLE;
			xKind_reg  <= sep_pkg::PK_WRITE;
			xAddr_reg  <= 6'h00;
			xData_reg  <= 16'h0000;
			timer_reg  <= 32'h0;
			for (int i = 0; i < sep_pkg::WORDS; i++) begin
				mem_reg[i] <= sep_pkg::ERASED;
			end
		end else begin
			xState_reg <= xState_next;
			xKind_reg  <= xKind_next;
			xAddr_reg  <= xAddr_next;
			xData_reg  <= xData_next;
			timer_reg  <= timer_next;
			mem_reg    <= mem_next;
		end
	end

	AST_TIMER_BOUND: assert property (@(posedge clock) disable iff (rst)
		(xState_reg != sep_pkg::X_IDLE) |-> timer_reg < 32'(BULK_CYC))
		else $error("Program timer beyond the longest cycle");
	AST_SELF_TIMED: assert property (@(posedge clock) disable iff (rst)
		(xState_reg != sep_pkg::X_IDLE && timer_reg != 32'h0) |=> timer_reg == $past(timer_reg) - 32'h1)
		else $error("Program timer stalled");
	AST_ERASE_BEFORE_WRITE: assert property (@(posedge clock) disable iff (rst)
		(xState_reg == sep_pkg::X_ERASE && timer_reg == 32'h0 && xKind_reg == sep_pkg::PK_WRITE)
		|=> xState_reg == sep_pkg::X_STORE && mem_reg[xAddr_reg] == sep_pkg::ERASED)
		else $error("Word not erased ahead of its write");

	// Ready/busy status: armed by a queued job, shown after a deselect
	logic armed_reg, armed_next, armLow_reg, armLow_next, statusDrive;
	logic outBit_reg, outBit_next, outEn_reg, outEn_next, standby_reg, standby_next;

	always_comb begin
		busy        = pushValid || fifoOutValid || xState_reg != sep_pkg::X_IDLE;
		armed_next  = armed_reg;
		armLow_next = armLow_reg;
		if (pushDone) begin
			armed_next  = 1'b1;
			armLow_next = 1'b0;
		end else if (startSeen) begin
			armed_next  = 1'b0;
			armLow_next = 1'b0;
		end else if (!csNow && armed_reg) begin
			armLow_next = 1'b1;
		end
		statusDrive  = csNow && armLow_reg && decState_reg == sep_pkg::D_IDLE;
		outBit_next  = readEn_reg ? readBit_reg : !busy;
		outEn_next   = (readEn_reg && csNow) || statusDrive;
		standby_next = !csNow && !busy;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			armed_reg   <= 1'b0;
			armLow_reg  <= 1'b0;
			outBit_reg  <= 1'b0;
			outEn_reg   <= 1'b0;
			standby_reg <= 1'b1;
		end else begin
			armed_reg   <= armed_next;
			armLow_reg  <= armLow_next;
			outBit_reg  <= outBit_next;
			outEn_reg   <= outEn_next;
			standby_reg <= standby_next;
		end
	end

	assign serialOut   = outBit_reg;
	assign serialOutEn = outEn_reg;
	assign standby     = standby_reg;

	AST_STANDBY_WAITS: assert property (@(posedge clock) disable iff (rst)
		busy |=> !standby_reg)
		else $error("Standby entered during a program cycle");
	AST_STANDBY_DESELECT: assert property (@(posedge clock) disable iff (rst)
		(!csNow && !busy) |=> standby_reg && !outEn_reg)
		else $error("Deselected idle device not in standby");
	AST_STATUS_BUSY_LOW: assert property (@(posedge clock) disable iff (rst)
		(statusDrive && !readEn_reg && xState_reg != sep_pkg::X_IDLE) |=> outEn_reg && !outBit_reg)
		else $error("Status did not show busy");

endmodule : sep_serial_eeprom

`default_nettype wire

// File: sep_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM pin-side logic.
// Assumes: 250 MHz system clock; the serial pins are asynchronous to it.
// Notes:   Program times are given in ms and turned into clock counts here.
`default_nettype none

package sep_pkg;

	// Clock and self-timed cycle lengths
	localparam int unsigned CLK_MHZ         = 250;
	localparam int unsigned WRITE_TIME_MS   = 2;
	localparam int unsigned ERASE_TIME_MS   = 1;
	localparam int unsigned BULK_TIME_MS    = 15;
	localparam int unsigned WRITE_CYCLES    = WRITE_TIME_MS * 1000 * CLK_MHZ;
	localparam int unsigned ERASE_CYCLES    = ERASE_TIME_MS * 1000 * CLK_MHZ;
	localparam int unsigned BULK_CYCLES     = BULK_TIME_MS * 1000 * CLK_MHZ;
	// Host-side gap, kept for reference by the far end
	localparam int unsigned DESELECT_GAP_NS = 100;

	// Array shape
	localparam int unsigned WORDS   = 64;
	localparam int unsigned WORD_W  = 16;
	localparam int unsigned ADDR_W  = 6;
	localparam logic [15:0] ERASED  = 16'hFFFF;

	// Frame field positions and bit counts
	localparam int unsigned OP_HI       = 7;
	localparam int unsigned OP_LO       = 6;
	localparam int unsigned SUB_HI      = 5;
	localparam int unsigned SUB_LO      = 4;
	localparam logic [3:0]  HEAD_LAST   = 4'h7;
	localparam logic [3:0]  DATA_LAST   = 4'hF;
	localparam logic [4:0]  READ_BITS   = 5'h10;
	localparam int unsigned FIFO_DEPTH  = 8;
	localparam int unsigned FIFO_W      = 2 + ADDR_W + WORD_W;

	// Opcodes and sub-commands of opcode 00
	localparam logic [1:0] OP_READ        = 2'h2;
	localparam logic [1:0] OP_WRITE       = 2'h1;
	localparam logic [1:0] OP_ERASE       = 2'h3;
	localparam logic [1:0] OP_SPECIAL     = 2'h0;
	localparam logic [1:0] SUB_UNLOCK     = 2'h3;
	localparam logic [1:0] SUB_LOCK       = 2'h0;
	localparam logic [1:0] SUB_ERASE_ALL  = 2'h2;
	localparam logic [1:0] SUB_WRITE_ALL  = 2'h1;

	// Program job kinds carried through the FIFO
	typedef enum logic [1:0] {
		PK_WRITE     = 2'h0,
		PK_ERASE     = 2'h1,
		PK_ERASE_ALL = 2'h2,
		PK_WRITE_ALL = 2'h3
	} sep_kind_t;

	// Instruction decoder states
	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_HEAD = 3'h1,
		D_DATA = 3'h2,
		D_READ = 3'h3,
		D_PUSH = 3'h4,
		D_DONE = 3'h5
	} sep_dec_t;

	// Self-timed executor states
	typedef enum logic [1:0] {
		X_IDLE  = 2'h0,
		X_ERASE = 2'h1,
		X_STORE = 2'h2
	} sep_exec_t;

endpackage : sep_pkg

`default_nettype wire

// File: sep_host_model.sv
// Purpose: Host controller model driving the serial pins of the EEPROM.
// Assumes: Pin changes land just after a system clock edge; 8 to 11-cycle half bit.
// Notes:   Random pauses stretch the serial clock at either level.
`default_nettype none

module sep_host_model (
	// Clock
	input  wire logic clock,
	// Pins toward the device
	output var logic  deviceSelect,
	output var logic  serialClock,
	output var logic  serialIn,
	input  wire logic serialOut,
	input  wire logic serialOutEn
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		deviceSelect = 1'b0;
		serialClock  = 1'b0;
		serialIn     = 1'b0;
	end

	// One bit; output sampled late, well after the launch edge settles
	task automatic clk_bit(input logic b, output logic seen);
		serialIn <= b;
		repeat (8 + $urandom_range(0, 3)) @(posedge clock);
		serialClock <= 1'b1;
		repeat (8 + $urandom_range(0, 3)) @(posedge clock);
		seen = serialOutEn ? serialOut : 1'b1; // Pull-up level once the device lets go
		serialClock <= 1'b0;
	endtask : clk_bit

	task automatic sel_up();
		@(posedge clock);
		deviceSelect <= 1'b1;
		serialIn     <= 1'b0;
		repeat (6) @(posedge clock);
	endtask : sel_up

	// Idle edges first: no start until serialIn is high
	task automatic head(input logic [8:0] h);
		logic s;
		sel_up();
		repeat ($urandom_range(0, 2)) clk_bit(1'b0, s);
		for (int i = 8; i >= 0; i--) clk_bit(h[i], s);
	endtask : head

	task automatic data16(input logic [15:0] d, output logic [15:0] q);
		for (int i = 15; i >= 0; i--) clk_bit(d[i], q[i]);
	endtask : data16

	// Released data line toggles so a stale level is never trusted
	task automatic drop();
		@(posedge clock);
		deviceSelect <= 1'b0;
		serialIn     <= ~serialIn;
		repeat (26) @(posedge clock);
	endtask : drop
endmodule : sep_host_model

`default_nettype wire

// File: tb_top.sv
// Purpose: Self-checking bench for the serial EEPROM pin logic.
// Assumes: Shortened program times; host model drives the pins.
// Notes:   Expected array contents kept in a shadow memory.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clock;
	logic        rst;
	logic        deviceSelect;
	logic        serialClock;
	logic        serialIn;
	logic        serialOut;
	logic        serialOutEn;
	logic        standby;
	int          errTotal;
	int          samplesChecked;
	int          cycles;
	logic [15:0] mem [64];
	logic [5:0]  a;
	logic [15:0] d;
	bit          progOpen;

	localparam int WR_T = 200;
	localparam int ER_T = 100;
	localparam int BK_T = 400;

	sep_serial_eeprom #(.WRITE_CYC(WR_T), .ERASE_CYC(ER_T), .BULK_CYC(BK_T)) i_sep_serial_eeprom (
		.clock(clock), .rst(rst), .deviceSelect(deviceSelect), .serialClock(serialClock),
		.serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn), .standby(standby));

	sep_host_model i_sep_host_model (
		.clock(clock), .deviceSelect(deviceSelect), .serialClock(serialClock),
		.serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn));

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			errTotal++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Timed length a frame should start; zero while programming is locked
	function automatic int job_len(input logic [8:0] h, input bit open);
		job_len = 0;
		if (open && h[7:6] == sep_pkg::OP_WRITE) job_len = WR_T;
		if (open && h[7:6] == sep_pkg::OP_ERASE) job_len = ER_T;
		if (open && h[7:4] == {sep_pkg::OP_SPECIAL, sep_pkg::SUB_WRITE_ALL}) job_len = BK_T;
		if (open && h[7:4] == {sep_pkg::OP_SPECIAL, sep_pkg::SUB_ERASE_ALL}) job_len = BK_T;
	endfunction : job_len

	// Program frame; expected timed length worked out from its header
	task automatic prog(input logic [8:0] h, input logic [15:0] dv, input bit hasData);
		logic [15:0] q;
		int n;
		int cyc;
		cyc = job_len(h, progOpen);
		i_sep_host_model.head(h);
		if (hasData) i_sep_host_model.data16(dv, q);
		i_sep_host_model.drop();
		check(standby, cyc == 0);
		i_sep_host_model.sel_up();
		check(serialOutEn, cyc > 0);
		if (cyc > 0) begin
			check(serialOut, 1'b0);
			for (n = 0; n < cyc && serialOut !== 1'b1; n++) @(posedge clock);
			check(serialOut, 1'b1);
		end
		i_sep_host_model.drop();
		check(standby, 1'b1);
		if (h[7:4] == {sep_pkg::OP_SPECIAL, sep_pkg::SUB_UNLOCK}) progOpen = 1'b1;
		if (h[7:4] == {sep_pkg::OP_SPECIAL, sep_pkg::SUB_LOCK}) progOpen = 1'b0;
	endtask : prog

	task automatic rd(input logic [5:0] ra);
		logic [15:0] q;
		logic s;
		i_sep_host_model.head({1'b1, sep_pkg::OP_READ, ra});
		check(serialOutEn, 1'b1);
		check(serialOut, 1'b0);
		i_sep_host_model.data16(16'($urandom), q);
		check(q, mem[ra]);
		i_sep_host_model.clk_bit(1'b1, s);
		check(serialOutEn, 1'b0);
		i_sep_host_model.drop();
	endtask : rd

	always @(posedge clock) begin
		cycles++;
		if (cycles == 80000) begin
			errTotal++;
			complete_run();
		end
	end

	initial begin
		logic s;
		rst = 1'b1;
		void'($urandom(32'h35DF1ED8));
		foreach (mem[i]) mem[i] = 16'hFFFF;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		repeat (6) @(posedge clock);
		check(standby, 1'b1);
		a = 6'($urandom);
		prog({1'b1, sep_pkg::OP_WRITE, a}, 16'h1234, 1'b1);
		rd(a);
		i_sep_host_model.sel_up();
		check(standby, 1'b0);
		i_sep_host_model.clk_bit(1'b1, s);
		i_sep_host_model.clk_bit(1'b1, s);
		i_sep_host_model.drop();
		i_sep_host_model.clk_bit(1'b1, s);
		check(s, 1'b1);
		check(standby, 1'b1);
		prog({1'b1, sep_pkg::OP_SPECIAL, sep_pkg::SUB_UNLOCK, 4'h0}, 16'h0, 1'b0);
		for (int k = 0; k < 4; k++) begin
			a = (k == 0) ? 6'h00 : (k == 1) ? 6'h3F : 6'($urandom);
			d = (k == 0) ? 16'h0000 : 16'($urandom);
			prog({1'b1, sep_pkg::OP_WRITE, a}, d, 1'b1);
			mem[a] = d;
			rd(a);
		end
		prog({1'b1, sep_pkg::OP_ERASE, a}, 16'h0, 1'b0);
		mem[a] = 16'hFFFF;
		rd(a);
		d = 16'($urandom);
		prog({1'b1, sep_pkg::OP_SPECIAL, sep_pkg::SUB_WRITE_ALL, 4'h5}, d, 1'b1);
		foreach (mem[i]) mem[i] = d;
		rd(6'($urandom));
		prog({1'b1, sep_pkg::OP_SPECIAL, sep_pkg::SUB_ERASE_ALL, 4'hA}, 16'h0, 1'b0);
		foreach (mem[i]) mem[i] = 16'hFFFF;
		rd(6'($urandom));
		prog({1'b1, sep_pkg::OP_SPECIAL, sep_pkg::SUB_LOCK, 4'h0}, 16'h0, 1'b0);
		prog({1'b1, sep_pkg::OP_WRITE, a}, 16'h0F0F, 1'b1);
		rd(a);
		complete_run();
	end
endmodule : tb_top

`default_nettype wire
